// >>> rtl/ebrg_pkg.sv
// Purpose: Shared constants and types for the bus request/grant block
// Assumes: Single 40 MHz processor clock
// Notes:   Active-low pin levels are named here once
package ebrg_pkg;
  localparam int  EBRG_SYNC_STAGES = 2;      // Request synchroniser depth
  localparam logic EBRG_PIN_ACTIVE = 1'b0;   // Level of an active low pin
  localparam logic EBRG_PIN_IDLE   = 1'b1;   // Level of an idle low pin
  localparam logic EBRG_OE_ON      = 1'b0;   // Enable level while driving
  localparam logic EBRG_OE_OFF     = 1'b1;   // Enable level when released

  // Arbiter states
  typedef enum logic [1:0] {
    EBRG_OWN,      // Processor owns the buses
    EBRG_WAIT,     // Request seen, external access still running
    EBRG_GRANTED   // Buses handed to the external master
  } ebrg_state_t;
endpackage : ebrg_pkg

// >>> rtl/ebrg_sync_if.sv
// Purpose: Carrier between the top and the request synchroniser
// Assumes: Both ends run on the processor clock
// Notes:   Raw level in, settled level out
`timescale 1ns/10ps
interface ebrg_sync_if;
  logic raw_level;
  logic settled_level;
  modport top  (output raw_level, input settled_level);
  modport sync (input raw_level, output settled_level);
endinterface : ebrg_sync_if

// >>> rtl/ebrg_sync.sv
// Purpose: Two-flop synchroniser for the asynchronous request pin
// Assumes: Idle level of the pin is high
// Notes:   First stage is read only by the second stage
`timescale 1ns/10ps
module ebrg_sync
  import ebrg_pkg::*;
(
  input  wire logic clock,
  input  wire logic resetn,
  ebrg_sync_if.sync sif
);
  logic meta_ff;
  logic settle_ff;

  // Resets to idle so no request appears out of reset
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta_ff   <= EBRG_PIN_IDLE;
      settle_ff <= EBRG_PIN_IDLE;
    end else begin
      meta_ff   <= sif.raw_level;
      settle_ff <= meta_ff;
    end
  end
  assign sif.settled_level = settle_ff;
endmodule : ebrg_sync

// >>> rtl/ebrg_arbiter.sv
// Purpose: External bus request/grant arbiter of the processor
// Assumes: Core reports access in progress, need and readiness per cycle
// Notes:   Emulator pins replace the normal ones while enabled
// Behaviour
// - Idle request grants next cycle: float buses, grant low, halt
// - Run-until-access mode keeps executing until an external access needed
// - Request during an access grants in the cycle after it ends
// - Grant may fall between two accesses of one instruction
// - Request release drops grant, re-enables drivers, resumes in place
// - Arbitration keeps working during reset and booting
// - Hung output low when ready to execute but halted with buses granted away
// - On release, grant and hung both deassert, pending access then runs
// - Emulator enable selects emulator reset, request, grant; grant pin floats
`timescale 1ns/10ps
module ebrg_arbiter
  import ebrg_pkg::*;
(
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic bus_request_n,
  input  wire logic emulator_enable,
  input  wire logic emulator_reset_n,
  input  wire logic emulator_bus_request_n,
  input  wire logic run_until_external_access,
  input  wire logic ext_access_busy,
  input  wire logic ext_access_needed,
  input  wire logic core_ready,
  output logic      bus_grant_n,
  output logic      bus_grant_oe,
  output logic      emulator_bus_grant_n,
  output logic      bus_grant_hung_n,
  output logic      bus_drive_oe,
  output logic      core_halt,
  output logic      core_reset_n
);
  ebrg_sync_if req_sif ();
  ebrg_sync_if emu_sif ();
  ebrg_state_t state_ff;
  ebrg_state_t nxt_state;
  logic        nxt_bg;
  logic        nxt_hung;
  logic        nxt_halt;

  // Both request sources go through a synchroniser
  assign req_sif.raw_level = bus_request_n;
  assign emu_sif.raw_level = emulator_bus_request_n;
  ebrg_sync u_req_sync (.clock(clock), .resetn(resetn), .sif(req_sif));
  ebrg_sync u_emu_sync (.clock(clock), .resetn(resetn), .sif(emu_sif));

  // Source selection; resetn is only the arbiter's power-on reset,
  // core reset passes through so arbitration survives it
  wire req_active = emulator_enable
                  ? (emu_sif.settled_level == EBRG_PIN_ACTIVE)
                  : (req_sif.settled_level == EBRG_PIN_ACTIVE);
  wire granted    = (state_ff == EBRG_GRANTED);

  // Next state; busy access defers grant to cycle after it completes
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      EBRG_OWN: begin
        if (req_active && !ext_access_busy)
          nxt_state = EBRG_GRANTED;
        else if (req_active)
          nxt_state = EBRG_WAIT;
      end
      EBRG_WAIT: begin
        if (!req_active)
          nxt_state = EBRG_OWN;
        else if (!ext_access_busy)
          nxt_state = EBRG_GRANTED;
      end
      EBRG_GRANTED: begin
        if (!req_active)
          nxt_state = EBRG_OWN;
      end
      default: nxt_state = EBRG_OWN;
    endcase
  end

  // Output terms; run-until-access halts only on a needed access
  wire nxt_granted = (nxt_state == EBRG_GRANTED);
  assign nxt_bg   = nxt_granted ? EBRG_PIN_ACTIVE : EBRG_PIN_IDLE;
  assign nxt_halt = nxt_granted &&
                    (!run_until_external_access || ext_access_needed);
  assign nxt_hung = (nxt_granted && core_ready && nxt_halt)
                    ? EBRG_PIN_ACTIVE : EBRG_PIN_IDLE;

  // Registered outputs; keeps running while core reset is low
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_ff             <= EBRG_OWN;
      bus_grant_n          <= EBRG_PIN_IDLE;
      emulator_bus_grant_n <= EBRG_PIN_IDLE;
      bus_grant_oe         <= EBRG_OE_ON;
      bus_grant_hung_n     <= EBRG_PIN_IDLE;
      bus_drive_oe         <= EBRG_OE_ON;
      core_halt            <= 1'b0;
      core_reset_n         <= 1'b0;
    end else begin
      state_ff             <= nxt_state;
      bus_grant_n          <= nxt_bg;
      emulator_bus_grant_n <= emulator_enable ? nxt_bg : EBRG_PIN_IDLE;
      bus_grant_oe         <= emulator_enable ? EBRG_OE_OFF
                                              : EBRG_OE_ON;
      bus_grant_hung_n     <= nxt_hung;
      bus_drive_oe         <= nxt_granted ? EBRG_OE_OFF : EBRG_OE_ON;
      core_halt            <= nxt_halt;
      core_reset_n         <= emulator_enable ? emulator_reset_n
                                              : 1'b1;
    end
  end

  // Checks
  a_grant_waits_idle: assert property (@(posedge clock) disable iff (!resetn)
    (nxt_state == EBRG_GRANTED && state_ff != EBRG_GRANTED) |->
      !ext_access_busy) else $error("grant during access");
  a_grant_drivers_off: assert property (@(posedge clock) disable iff (!resetn)
    (bus_grant_n == EBRG_PIN_ACTIVE) |-> (bus_drive_oe == EBRG_OE_OFF))
    else $error("drivers on while granted");
  a_grant_next_cycle: assert property (@(posedge clock) disable iff (!resetn)
    (state_ff == EBRG_OWN && req_active && !ext_access_busy) |=>
      (bus_grant_n == EBRG_PIN_ACTIVE)) else $error("grant late");
  a_release_drops: assert property (@(posedge clock) disable iff (!resetn)
    (granted && !req_active) |=> (bus_grant_n == EBRG_PIN_IDLE &&
      bus_grant_hung_n == EBRG_PIN_IDLE && bus_drive_oe == EBRG_OE_ON))
    else $error("release not honoured");
  a_hung_needs_grant: assert property (@(posedge clock) disable iff (!resetn)
    (bus_grant_hung_n == EBRG_PIN_ACTIVE) |-> (bus_grant_n == EBRG_PIN_ACTIVE))
    else $error("hung without grant");
  a_go_mode_runs: assert property (@(posedge clock) disable iff (!resetn)
    (nxt_granted && run_until_external_access && !ext_access_needed) |=>
      !core_halt) else $error("halted in run mode");
  a_hung_when_ready: assert property (@(posedge clock) disable iff (!resetn)
    (nxt_granted && core_ready && !run_until_external_access) |=>
      (bus_grant_hung_n == EBRG_PIN_ACTIVE)) else $error("hung missing");
  a_emu_floats_grant: assert property (@(posedge clock) disable iff (!resetn)
    emulator_enable |=> (bus_grant_oe == EBRG_OE_OFF))
    else $error("grant pin driven in emulation");
  a_sync_delay: assert property (@(posedge clock) disable iff (!resetn)
    (!emulator_enable && state_ff == EBRG_OWN &&
     $past(bus_request_n, 2) == EBRG_PIN_IDLE) |-> nxt_state == EBRG_OWN ||
     $past(emulator_enable, 2)) else $error("request not synchronised");

  // Deferred grant: nothing moves while the access is still running
  a_wait_no_grant: assert property (@(posedge clock) disable iff (!resetn)
    (state_ff == EBRG_WAIT && ext_access_busy) |=>
      (bus_grant_n == EBRG_PIN_IDLE && bus_drive_oe == EBRG_OE_ON))
    else $error("grant while access busy");
  a_wait_then_grant: assert property (@(posedge clock) disable iff (!resetn)
    (state_ff == EBRG_WAIT && req_active && !ext_access_busy) |=>
      (bus_grant_n == EBRG_PIN_ACTIVE))
    else $error("deferred grant late");
  a_hung_clears: assert property (@(posedge clock) disable iff (!resetn)
    (bus_grant_n == EBRG_PIN_IDLE) |-> (bus_grant_hung_n == EBRG_PIN_IDLE))
    else $error("hung left after release");
  a_halt_needs_grant: assert property (@(posedge clock) disable iff (!resetn)
    core_halt |-> (bus_grant_n == EBRG_PIN_ACTIVE))
    else $error("halted without grant");
  a_drivers_follow: assert property (@(posedge clock) disable iff (!resetn)
    (bus_drive_oe == EBRG_OE_OFF) |-> (bus_grant_n == EBRG_PIN_ACTIVE))
    else $error("drivers floated without grant");

  // Emulation swaps the pin set; normal pins must not leak through
  a_emu_copy_idle: assert property (@(posedge clock) disable iff (!resetn)
    !emulator_enable |=> (emulator_bus_grant_n == EBRG_PIN_IDLE))
    else $error("emulator grant outside emulation");
  a_grant_pin_driven: assert property (@(posedge clock) disable iff (!resetn)
    !emulator_enable |=> (bus_grant_oe == EBRG_OE_ON))
    else $error("grant pin floating in normal use");
  a_core_reset_pass: assert property (@(posedge clock) disable iff (!resetn)
    emulator_enable |=> (core_reset_n == $past(emulator_reset_n)))
    else $error("emulator reset not passed");
  a_core_reset_idle: assert property (@(posedge clock) disable iff (!resetn)
    !emulator_enable |=> core_reset_n)
    else $error("core reset low outside emulation");
  a_emu_ignores_pin: assert property (@(posedge clock) disable iff (!resetn)
    (emulator_enable && state_ff == EBRG_OWN &&
     emu_sif.settled_level == EBRG_PIN_IDLE) |-> (nxt_state == EBRG_OWN))
    else $error("normal request seen in emulation");
  a_keeps_grant: assert property (@(posedge clock) disable iff (!resetn)
    (granted && req_active) |=> (bus_grant_n == EBRG_PIN_ACTIVE))
    else $error("grant dropped while requested");

  // Scenarios worth seeing at least once
  c_grant: cover property (@(posedge clock) disable iff (!resetn)
    (state_ff == EBRG_OWN) ##1 granted);
  c_deferred: cover property (@(posedge clock) disable iff (!resetn)
    (state_ff == EBRG_WAIT) ##1 granted);
  c_hung: cover property (@(posedge clock) disable iff (!resetn)
    (bus_grant_hung_n == EBRG_PIN_ACTIVE));
  c_emulated: cover property (@(posedge clock) disable iff (!resetn)
    emulator_enable && granted);
  // Go mode: buses handed over while the core keeps running
  c_go_running: cover property (@(posedge clock) disable iff (!resetn)
    granted && run_until_external_access && !core_halt);
endmodule : ebrg_arbiter

// >>> tb/ebrg_master_model.sv
// Purpose: External bus master model facing the grant pins
// Assumes: Bench says when the master wants the buses
// Notes:   Request is a plain level; no glitches on release
`timescale 1ns/10ps
module ebrg_master_model (
  input  wire logic want_bus,
  input  wire logic bus_grant_n,
  output logic      bus_request_n
);
  // Hold request low for as long as the buses are wanted
  assign bus_request_n = want_bus ? 1'h0 : 1'h1;
endmodule : ebrg_master_model

// >>> tb/external_bus_request_grant_tb.sv
// Purpose: Self-checking bench for the bus request/grant arbiter
// Assumes: 40 MHz clock, request seen three edges after the pin
// Notes:   Rows cover mode and readiness; waits are hand-written
`timescale 1ns/10ps
module external_bus_request_grant_tb;
  import ebrg_pkg::*;
  typedef struct packed {logic go, need, rdy, halt, hung;} ebrg_row_t;
  logic      clock, resetn, want, emu_en, emu_rst_n, emu_req_n;
  logic      go, busy, need, rdy;
  wire logic req_n, gnt_n, gnt_oe, emu_gnt_n, hung_n, drv_oe, halt, crst_n;
  int        mismatches, total_checks;
  // Mode, need, ready, then expected halt and hung level
  ebrg_row_t rows [4] = '{5'h06, 5'h03, 5'h15, 5'h1E};

  ebrg_master_model MST (.want_bus(want), .bus_grant_n(gnt_n),
    .bus_request_n(req_n));
  ebrg_arbiter DUT (.clock(clock), .resetn(resetn), .bus_request_n(req_n),
    .emulator_enable(emu_en), .emulator_reset_n(emu_rst_n),
    .emulator_bus_request_n(emu_req_n), .run_until_external_access(go),
    .ext_access_busy(busy), .ext_access_needed(need), .core_ready(rdy),
    .bus_grant_n(gnt_n), .bus_grant_oe(gnt_oe),
    .emulator_bus_grant_n(emu_gnt_n), .bus_grant_hung_n(hung_n),
    .bus_drive_oe(drv_oe), .core_halt(halt), .core_reset_n(crst_n));

  // Free-running processor clock
  initial begin
    clock = 1'h0;
    forever #12.5 clock = ~clock;
  end

  task automatic chk(input string n, input logic s, input logic e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, s);
    end
  endtask : chk

  // Sample just after the edge so its updates have landed
  task automatic edges(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : edges

  task automatic release_bus();
    @(posedge clock);
    want <= 1'h0;
    edges(3);
    chk("grant released", gnt_n, 1'h1);
    chk("drivers back", drv_oe, 1'h0);
    chk("resumed", halt, 1'h0);
    chk("hung released", hung_n, 1'h1);
  endtask : release_bus

  task automatic complete_run();
    $display("Checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run

  // Watchdog far beyond the roughly 70 cycles the tests need
  initial begin
    #20000;
    mismatches++;
    complete_run();
  end

  initial begin
    {want, emu_en, go, busy, need, resetn} = 6'h00;
    {emu_rst_n, emu_req_n, rdy} = 3'h7;
    mismatches = 0;
    total_checks = 0;
    edges(4);
    chk("grant in reset", gnt_n, 1'h1);
    @(posedge clock);
    resetn <= 1'h1;
    // Plain grants over modes and core readiness
    foreach (rows[i]) begin
      @(posedge clock);
      {go, need, rdy, want} <= {rows[i].go, rows[i].need, rows[i].rdy, 1'h1};
      edges(3);
      chk("grant", gnt_n, 1'h0);
      chk("drivers off", drv_oe, 1'h1);
      edges(1);
      chk("halt", halt, rows[i].halt);
      chk("hung", hung_n, rows[i].hung);
      release_bus();
      $display("Row %0d done", i);
    end
    // Request during an access waits for the access to end
    @(posedge clock);
    {busy, want} <= 2'h3;
    edges(5);
    chk("no grant busy", gnt_n, 1'h1);
    chk("drivers kept", drv_oe, 1'h0);
    @(posedge clock);
    busy <= 1'h0;
    edges(2);
    chk("grant after access", gnt_n, 1'h0);
    release_bus();
    $display("Busy test done");
    // Emulator pins take over while the core is held in reset
    @(posedge clock);
    {emu_en, emu_rst_n, emu_req_n} <= 3'h4;
    edges(4);
    chk("emu grant", emu_gnt_n, 1'h0);
    chk("grant pin float", gnt_oe, 1'h1);
    chk("core reset", crst_n, 1'h0);
    @(posedge clock);
    emu_req_n <= 1'h1;
    edges(3);
    chk("emu released", emu_gnt_n, 1'h1);
    @(posedge clock);
    {want, emu_rst_n} <= 2'h3;
    edges(4);
    chk("normal pin ignored", emu_gnt_n, 1'h1);
    chk("core reset freed", crst_n, 1'h1);
    @(posedge clock);
    want <= 1'h0;
    edges(1);
    $display("Emulator test done");
    complete_run();
  end
endmodule : external_bus_request_grant_tb
